// file: rtl/ipr_top.sv
// peripheral interrupt flags, enables and reset cause over ahb-lite
`timescale 1ns/1ps
module ipr_top
    import ipr_pkg::*;
#(
    parameter int HAS_CONVERTER = 1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timer0_ovf_evt,
    input  wire logic        ext_pin_evt,
    input  wire logic        port_change_evt,
    input  wire logic        converter_evt,
    input  wire logic        serial_rx_evt,
    input  wire logic        serial_tx_evt,
    input  wire logic        sync_port_evt,
    input  wire logic        capcomp_evt,
    input  wire logic        timer2_match_evt,
    input  wire logic        timer1_ovf_evt,
    input  wire logic        nvm_write_done_evt,
    input  wire logic        comparator_change_evt,
    input  wire logic        osc_fail_evt,
    input  wire logic        brownout_reset,
    input  wire logic        brownout_detect_cfg,
    output logic             core_irq_req,
    output logic             irq
);

    // variant check: converter present or not, nothing else
    if (HAS_CONVERTER != 0 && HAS_CONVERTER != 1) begin : g_chk
        $error("HAS_CONVERTER must be 0 or 1");
    end

    // converter bit vanishes on the variant without it
    localparam logic [7:0] FA_MASK = (HAS_CONVERTER == 1) ? MASK_FLAGS_A
        : (MASK_FLAGS_A & ~(8'h01 << CONVERTER_BIT));

    // register map: one byte per aligned word, bits 31:8 read zero
    //
    // int_global_ctrl, index 0x00b, also wherever index[6:0] is 0x0b
    //   bit 7    global_irq_enable, master gate on the core request
    //   bit 6    periph_group_enable, gates every peripheral source
    //   bit 5    timer0_ovf_enable
    //   bit 4    ext_pin_irq_enable
    //   bit 3    port_change_enable
    //   bit 2    timer0_ovf_flag, set by its strobe
    //   bit 1    ext_pin_irq_flag, set by its strobe
    //   bit 0    port_change_flag, set by its strobe
    //
    // periph_flags_a, index 0x00c
    //   bit 7    spare, reads zero
    //   bit 6    converter_flag, converter build only
    //   bit 5    serial_rx_flag
    //   bit 4    serial_tx_flag
    //   bit 3    sync_port_flag
    //   bit 2    capcomp_flag
    //   bit 1    timer2_match_flag
    //   bit 0    timer1_ovf_flag
    //
    // periph_flags_b, index 0x00d
    //   bit 7    osc_fail_flag, clock fell back to internal_rc_osc
    //   bit 6    comparator_change_flag
    //   bit 5    spare, reads zero
    //   bit 4    nvm_write_done_flag
    //   bits 3:0 spare, read zero
    //
    // periph_enables_a, index 0x08c, positions as in periph_flags_a
    //   bit 7    spare, reads zero
    //   bit 6    converter_enable, converter build only
    //   bit 5    serial_rx_enable
    //   bit 4    serial_tx_enable
    //   bit 3    sync_port_enable
    //   bit 2    capcomp_enable
    //   bit 1    timer2_match_enable
    //   bit 0    timer1_ovf_enable
    //
    // reset_cause, index 0x08e
    //   bits 7:2 spare, read zero
    //   bit 1    power-on status, zero after hresetn
    //   bit 0    brownout_status, zero after a counted brown-out
    //
    // evt_status, index 0x1f0, write one to clear
    //   bit 2    some periph_flags_b bit was set
    //   bit 1    some periph_flags_a bit was set
    //   bit 0    some core flag was set
    //
    // evt_mask, index 0x1f1, same layout, plain read and write
    //
    // every other index reads zero and drops writes
    //
    // bus timing
    //   zero wait states; hreadyout never drops, response always okay
    //   the address phase decodes the index and registers the read byte
    //   write data is taken one edge later, in the data phase
    //   a write lands at the edge that ends its data phase
    //   a read whose address phase meets a write's data phase sees the
    //   old value: the trade for a read path with no write bypass
    //   hsize is not looked at; only whole-word transfers are expected
    //   haddr[1:0] and haddr[31:11] are ignored
    //   hwdata[31:8] is ignored; the event registers use bits 2:0
    //   hrdata is zero outside a read data phase
    //
    // flag behaviour
    //   strobes set flags whatever the enables say
    //   a strobe held high sets its flag again on every edge
    //   a software write stores the byte: zero clears, one sets
    //   a strobe in the same cycle as a write wins, so no event is lost
    //   software should clear a flag before setting its enable, or a
    //   stale flag raises a request at once
    //   converter bit 6 is tied to zero on the build without it
    //   flags have no clear-on-read; software clears them by writing
    //
    // request to the core
    //   global enable and a core flag with its enable, or
    //   global and group enable and a peripheral flag with its enable
    //   periph_flags_b has no enable register, so any set bit counts
    //   combinational from registers, so it follows a flag in its cycle
    //   the core request does not look at evt_mask
    //
    // summary interrupt
    //   irq is high while evt_status and evt_mask share a set bit
    //   it ignores the enables, so polled code can still be woken
    //
    // brown-out handling
    //   brownout_reset is a one-cycle strobe, synchronous to hclk
    //   ignored while brownout_detect_cfg is low
    //   clears control, flags and enables as hresetn does
    //   clears reset_cause bit 0, keeps bit 1 as software left it
    //   strobes in the same cycle are dropped from the flags; the reset wins
    //   evt_status and evt_mask ride through it
    //
    // limitations
    //   the brown-out status after hresetn is really unknown; it is
    //   forced to zero here so that simulation starts from known state
    //   with the detector disabled that bit carries no meaning
    //   only int_global_ctrl is mirrored across the four banks
    //   a held brownout_reset keeps the registers cleared
    //   every register sits in flip-flops; there is no memory macro

    logic [7:0]       int_global_ctrl;
    logic [7:0]       periph_flags_a;
    logic [7:0]       periph_flags_b;
    logic [7:0]       periph_enables_a;
    logic [1:0]       reset_cause;
    logic [2:0]       evt_status;
    logic [2:0]       evt_mask;
    logic [7:0]       next_int_global_ctrl;
    logic [7:0]       next_periph_flags_a;
    logic [7:0]       next_periph_flags_b;
    logic [2:0]       set_core;
    logic [7:0]       set_a;
    logic [7:0]       set_b;
    logic             wr_pend;
    logic [IDX_W-1:0] wr_idx;
    logic             wr_ctrl;
    logic             wr_fa;
    logic             wr_fb;
    logic             wr_ea;
    logic             wr_rc;
    logic             wr_es;
    logic             wr_em;
    logic             rd_go;
    logic             wr_go;
    logic [IDX_W-1:0] a_idx;
    logic [7:0]       rd_val;
    logic             bor_hit;
    logic             core_hit;
    logic             periph_hit;

    // zero wait state slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // address phase qualification
    assign a_idx = haddr[ADDR_LSB +: IDX_W];
    assign rd_go = hsel & hready & htrans[1] & ~hwrite;
    assign wr_go = hsel & hready & htrans[1] & hwrite;

    // write address held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= '0;
        end else begin
            wr_pend <= wr_go;
            wr_idx  <= a_idx;
        end
    end

    // write strobes in the data phase; ctrl mirrors across banks
    assign wr_ctrl = wr_pend & (wr_idx[BANK_LOW_W-1:0]
                     == IDX_INT_GLOBAL_CTRL[BANK_LOW_W-1:0]);
    assign wr_fa   = wr_pend & (wr_idx == IDX_FLAGS_A);
    assign wr_fb   = wr_pend & (wr_idx == IDX_FLAGS_B);
    assign wr_ea   = wr_pend & (wr_idx == IDX_ENABLES_A);
    assign wr_rc   = wr_pend & (wr_idx == IDX_RESET_CAUSE);
    assign wr_es   = wr_pend & (wr_idx == IDX_EVT_STATUS);
    assign wr_em   = wr_pend & (wr_idx == IDX_EVT_MASK);

    // brown-out only counts while the detector is enabled
    assign bor_hit = brownout_reset & brownout_detect_cfg;

    // hardware set strobes, taken whatever the enables say
    assign set_core = {timer0_ovf_evt, ext_pin_evt, port_change_evt};
    assign set_a    = {1'b0, converter_evt, serial_rx_evt, serial_tx_evt,
                       sync_port_evt, capcomp_evt, timer2_match_evt,
                       timer1_ovf_evt} & FA_MASK;
    assign set_b    = {osc_fail_evt, comparator_change_evt, 1'b0,
                       nvm_write_done_evt, 4'h0};

    // per-bit flag update: a set in the same cycle beats the write
    for (genvar i = 0; i < 8; i++) begin : g_flag
        assign next_periph_flags_a[i] = FA_MASK[i] & (set_a[i]
            | (wr_fa ? hwdata[i] : periph_flags_a[i]));
        assign next_periph_flags_b[i] = MASK_FLAGS_B[i] & (set_b[i]
            | (wr_fb ? hwdata[i] : periph_flags_b[i]));
        if (i < 3) begin : g_core
            assign next_int_global_ctrl[i] = set_core[i]
                | (wr_ctrl ? hwdata[i] : int_global_ctrl[i]);
        end else begin : g_en
            assign next_int_global_ctrl[i] = wr_ctrl ? hwdata[i]
                                             : int_global_ctrl[i];
        end
    end

    // global control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_global_ctrl <= RST_INT_CTRL;
        end else if (bor_hit) begin
            int_global_ctrl <= RST_INT_CTRL;
        end else begin
            int_global_ctrl <= next_int_global_ctrl;
        end
    end

    // peripheral flag registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_flags_a <= RST_FLAGS_A;
            periph_flags_b <= RST_FLAGS_B;
        end else if (bor_hit) begin
            periph_flags_a <= RST_FLAGS_A;
            periph_flags_b <= RST_FLAGS_B;
        end else begin
            periph_flags_a <= next_periph_flags_a;
            periph_flags_b <= next_periph_flags_b;
        end
    end

    // peripheral enables; software should clear a flag first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_enables_a <= RST_ENABLES_A;
        end else if (bor_hit) begin
            periph_enables_a <= RST_ENABLES_A;
        end else if (wr_ea) begin
            periph_enables_a <= hwdata[7:0] & FA_MASK;
        end
    end

    // reset cause: power-on clears both, the brown-out bit is not
    // trustworthy after power-on and software must set it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_cause <= RST_RST_CAUSE;
        end else if (bor_hit) begin
            reset_cause[BOR_STATUS_BIT] <= 1'b0;
        end else if (wr_rc) begin
            reset_cause <= hwdata[1:0];
        end
    end

    // interrupt request to the core
    assign core_hit   = |(int_global_ctrl[CORE_EN_LSB +: 3]
                          & int_global_ctrl[CORE_FLAG_LSB +: 3]);
    assign periph_hit = int_global_ctrl[GROUP_EN_BIT]
                        & (|(periph_enables_a & periph_flags_a)
                        | |(MASK_FLAGS_B & periph_flags_b));
    assign core_irq_req = int_global_ctrl[GLOBAL_EN_BIT]
                          & (core_hit | periph_hit);

    // event summary: sticky, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_status <= RST_EVT;
        end else begin
            evt_status <= ((wr_es ? (evt_status & ~hwdata[2:0]) : evt_status)
                          | {|set_b, |set_a, |set_core});
        end
    end

    // summary mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_mask <= RST_EVT;
        end else if (wr_em) begin
            evt_mask <= hwdata[2:0];
        end
    end

    assign irq = |(evt_status & evt_mask);

    // read mux for the address phase
    always_comb begin
        rd_val = 8'h00;
        if (a_idx[BANK_LOW_W-1:0]
            == IDX_INT_GLOBAL_CTRL[BANK_LOW_W-1:0]) begin
            rd_val = int_global_ctrl;
        end else begin
            case (a_idx)
                IDX_FLAGS_A:     rd_val = periph_flags_a & FA_MASK;
                IDX_FLAGS_B:     rd_val = periph_flags_b & MASK_FLAGS_B;
                IDX_ENABLES_A:   rd_val = periph_enables_a & FA_MASK;
                IDX_RESET_CAUSE: rd_val = {6'h00, reset_cause};
                IDX_EVT_STATUS:  rd_val = {5'h00, evt_status};
                IDX_EVT_MASK:    rd_val = {5'h00, evt_mask};
                default:         rd_val = 8'h00;
            endcase
        end
    end

    // read data registered so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata <= {24'h00_0000, rd_val};
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

endmodule : ipr_top

// file: rtl/ipr_pkg.sv
// constants for the peripheral interrupt and reset cause register block
// Operation
// - enables_a: one enable per source, bit7 zero
// - peripheral irq needs group enable bit 6
// - flags set regardless of any enable
// - flags_b bit4 set on nvm write done
// - flags_b bit7 set on oscillator failure
// - flags_b bit6 set on comparator change
// - unimplemented bits read as zero
// - converter bits only on converter variant
// - reset cause bit0 cleared by brown-out
// - brown-out bit undefined after power-on; the code forces it to zero on hresetn
// - brown-out bit meaningless when detector disabled
// - global ctrl: enables 7..3, flags 2..0
// - flags_a bits match enables_a positions
// - global ctrl mirrored in every bank
// - unmapped addresses read zero
package ipr_pkg;
    // register indices; byte address is four times the index
    localparam int         IDX_W               = 9;
    localparam int         ADDR_LSB            = 2;
    localparam logic [8:0] IDX_INT_GLOBAL_CTRL = 9'h00b;
    localparam logic [8:0] IDX_FLAGS_A         = 9'h00c;
    localparam logic [8:0] IDX_FLAGS_B         = 9'h00d;
    localparam logic [8:0] IDX_ENABLES_A       = 9'h08c;
    localparam logic [8:0] IDX_RESET_CAUSE     = 9'h08e;
    localparam logic [8:0] IDX_EVT_STATUS      = 9'h1f0;
    localparam logic [8:0] IDX_EVT_MASK        = 9'h1f1;
    localparam int         BANK_LOW_W          = 7;

    // field positions
    localparam int GLOBAL_EN_BIT   = 7;
    localparam int GROUP_EN_BIT    = 6;
    localparam int CORE_EN_LSB     = 3;
    localparam int CORE_FLAG_LSB   = 0;
    localparam int CONVERTER_BIT   = 6;
    localparam int NVM_DONE_BIT    = 4;
    localparam int CMP_CHANGE_BIT  = 6;
    localparam int OSC_FAIL_BIT    = 7;
    localparam int POR_STATUS_BIT  = 1;
    localparam int BOR_STATUS_BIT  = 0;

    // implemented bits
    localparam logic [7:0] MASK_FLAGS_A  = 8'h7f;
    localparam logic [7:0] MASK_FLAGS_B  = 8'hd0;
    localparam logic [7:0] MASK_RST_CAUSE = 8'h03;

    // values after reset
    localparam logic [7:0] RST_INT_CTRL  = 8'h00;
    localparam logic [7:0] RST_FLAGS_A   = 8'h00;
    localparam logic [7:0] RST_FLAGS_B   = 8'h00;
    localparam logic [7:0] RST_ENABLES_A = 8'h00;
    localparam logic [1:0] RST_RST_CAUSE = 2'h0;
    localparam logic [2:0] RST_EVT       = 3'h0;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage : ipr_pkg

// file: testbench/ipr_checker.sv
// concurrent checks on the ports of the interrupt flag block
`timescale 1ns/1ps
module ipr_checker
    import ipr_pkg::*;
#(
    parameter int HAS_CONVERTER = 1
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        timer1_ovf_evt,
    input wire logic        nvm_write_done_evt,
    input wire logic        comparator_change_evt,
    input wire logic        osc_fail_evt,
    input wire logic        brownout_reset,
    input wire logic        brownout_detect_cfg
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // brown-out wipes flags, so it must not fall between event and read
    wire logic       bor = brownout_reset && brownout_detect_cfg;
    wire logic       rd  = hsel && hready && htrans[1] && !hwrite;
    wire logic [8:0] ix  = haddr[10:2];
    property p_seen(ev, logic [8:0] idx, int b);
        ev && !bor ##1 rd && ix == idx && !bor |=> hrdata[b];
    endproperty
    AST_BUS_OKAY: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave not ready or not okay");
    AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (
        rd && (ix == 9'h01b || ix == 9'h01d) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RC_BITS: assert property (rd && ix == IDX_RESET_CAUSE
        |=> hrdata[7:2] == 6'h0) else $error("reset cause top bits set");
    AST_FB_BITS: assert property (rd && ix == IDX_FLAGS_B
        |=> hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
        else $error("flags b spare bits set");
    AST_EA_TOP: assert property (rd && ix == IDX_ENABLES_A
        |=> !hrdata[7] && (HAS_CONVERTER != 0 || !hrdata[6]))
        else $error("enables a spare bits set");
    AST_T1_FLAG: assert property (
        p_seen(timer1_ovf_evt, IDX_FLAGS_A, 0))
        else $error("timer1 flag missing");
    AST_NVM_FLAG: assert property (
        p_seen(nvm_write_done_evt, IDX_FLAGS_B, 4))
        else $error("nvm done flag missing");
    AST_CMP_FLAG: assert property (
        p_seen(comparator_change_evt, IDX_FLAGS_B, 6))
        else $error("comparator flag missing");
    AST_OSC_FLAG: assert property (
        p_seen(osc_fail_evt, IDX_FLAGS_B, 7))
        else $error("oscillator fail flag missing");
    AST_BOR_CLEAR: assert property (
        bor ##1 rd && ix == IDX_RESET_CAUSE |=> !hrdata[0])
        else $error("brown-out status not cleared");
    cover property (bor ##1 rd && ix == IDX_RESET_CAUSE);
    cover property (osc_fail_evt ##1 rd && ix == IDX_FLAGS_B);
    cover property (rd && (ix == 9'h01b || ix == 9'h01d));
endmodule : ipr_checker

bind ipr_top ipr_checker #(.HAS_CONVERTER(HAS_CONVERTER)) u_chk (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .timer1_ovf_evt, .nvm_write_done_evt, .comparator_change_evt,
    .osc_fail_evt, .brownout_reset, .brownout_detect_cfg);

// file: testbench/ipr_periph_model.sv
// event strobe source standing in for the core and its peripherals
`timescale 1ns/1ps
module ipr_periph_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [13:0] fire,
    output logic      [13:0] evt
);
    // one strobe per cycle asked, launched on the edge after the ask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt <= 14'h0;
        end else begin
            evt <= fire;
        end
    end
endmodule : ipr_periph_model

// file: testbench/test_periph_irq_and_reset_flags.sv
// self-checking bench for the interrupt flag and reset cause block
`timescale 1ns/1ps
module test_periph_irq_and_reset_flags
    import ipr_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [31:0] hrdata_nc, rv_nc;
    logic [1:0]  htrans = 2'h0;
    logic [13:0] fire = 14'h0, evt;
    logic        cfg = 1'b1, hreadyout, hresp, core_irq_req, irq;
    int          fail_count = 0, total_checks = 0;
    always #2.5 hclk = ~hclk;
    ipr_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .timer0_ovf_evt(evt[2]), .ext_pin_evt(evt[1]),
        .port_change_evt(evt[0]), .converter_evt(evt[9]),
        .serial_rx_evt(evt[8]), .serial_tx_evt(evt[7]),
        .sync_port_evt(evt[6]), .capcomp_evt(evt[5]),
        .timer2_match_evt(evt[4]), .timer1_ovf_evt(evt[3]),
        .nvm_write_done_evt(evt[10]), .comparator_change_evt(evt[11]),
        .osc_fail_evt(evt[12]), .brownout_reset(evt[13]),
        .brownout_detect_cfg(cfg), .core_irq_req, .irq);
    ipr_periph_model u_model (.hclk, .hresetn, .fire, .evt);
    // second copy built without the converter, read back alongside
    ipr_top #(.HAS_CONVERTER(0)) dut_noconv (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout(), .hresp(), .hrdata(hrdata_nc),
        .timer0_ovf_evt(evt[2]), .ext_pin_evt(evt[1]),
        .port_change_evt(evt[0]), .converter_evt(evt[9]),
        .serial_rx_evt(evt[8]), .serial_tx_evt(evt[7]),
        .sync_port_evt(evt[6]), .capcomp_evt(evt[5]),
        .timer2_match_evt(evt[4]), .timer1_ovf_evt(evt[3]),
        .nvm_write_done_evt(evt[10]), .comparator_change_evt(evt[11]),
        .osc_fail_evt(evt[12]), .brownout_reset(evt[13]),
        .brownout_detect_cfg(cfg), .core_irq_req(), .irq());
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // bounded wait, a stuck slave ends the run instead of hanging it
    task automatic wait_rdy;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask : wait_rdy
    // single word transfer; ev lands on the data phase edge
    task automatic bus(input logic w, input logic [8:0] ix,
                       input logic [7:0] d, input logic [13:0] ev = 14'h0);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {21'h0, ix, 2'h0};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        fire <= ev;
        wait_rdy();
        fire <= 14'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rv = hrdata;
        rv_nc = hrdata_nc;
    endtask : bus
    task automatic rdc(input logic [8:0] ix, input logic [7:0] e);
        bus(1'b0, ix, 8'h00);
        chk(rv, {24'h0, e});
    endtask : rdc
    task automatic pulse(input logic [13:0] ev);
        @(posedge hclk);
        fire <= ev;
        @(posedge hclk);
        fire <= 14'h0;
    endtask : pulse
    task automatic irqc(input logic r, input logic i);
        @(negedge hclk);
        chk({30'h0, core_irq_req, irq}, {30'h0, r, i});
    endtask : irqc
    task automatic t_reset;
        rdc(IDX_INT_GLOBAL_CTRL, 8'h00);
        rdc(IDX_FLAGS_A, 8'h00);
        rdc(IDX_FLAGS_B, 8'h00);
        rdc(IDX_ENABLES_A, 8'h00);
        rdc(IDX_RESET_CAUSE, 8'h00);
        rdc(9'h01b, 8'h00);
        rdc(9'h01d, 8'h00);
    endtask : t_reset
    task automatic t_access;
        logic [8:0] ix [5] = '{IDX_INT_GLOBAL_CTRL, IDX_FLAGS_A,
            IDX_FLAGS_B, IDX_ENABLES_A, IDX_RESET_CAUSE};
        logic [7:0] ex [5] = '{8'hff, 8'h7f, 8'hd0, 8'h7f, 8'h03};
        logic [7:0] exn [5] = '{8'hff, 8'h3f, 8'hd0, 8'h3f, 8'h03};
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ix[i], 8'hff);
            rdc(ix[i], ex[i]);
            chk(rv_nc, {24'h0, exn[i]});
            bus(1'b1, ix[i], 8'h00);
        end
        bus(1'b1, 9'h10b, 8'h38);
        rdc(9'h18b, 8'h38);
    endtask : t_access
    // flags rise with the core enables on and every other enable off, then the request gating
    task automatic t_events;
        pulse(14'h1fff);
        rdc(IDX_FLAGS_B, 8'hd0);
        rdc(IDX_FLAGS_A, 8'h7f);
        chk(rv_nc, 32'h0000_003f);
        rdc(IDX_INT_GLOBAL_CTRL, 8'h3f);
        irqc(1'b0, 1'b0);
        bus(1'b1, IDX_INT_GLOBAL_CTRL, 8'h8f);
        irqc(1'b1, 1'b0);
        bus(1'b1, IDX_FLAGS_B, 8'h00);
        bus(1'b1, IDX_ENABLES_A, 8'h01);
        bus(1'b1, IDX_INT_GLOBAL_CTRL, 8'h80);
        irqc(1'b0, 1'b0);
        bus(1'b1, IDX_INT_GLOBAL_CTRL, 8'hc0);
        irqc(1'b1, 1'b0);
        bus(1'b1, IDX_ENABLES_A, 8'h00);
        irqc(1'b0, 1'b0);
        bus(1'b1, IDX_INT_GLOBAL_CTRL, 8'h00);
        bus(1'b1, IDX_FLAGS_B, 8'h00, 14'h1000);
        rdc(IDX_FLAGS_B, 8'h80);
    endtask : t_events
    task automatic t_brownout;
        bus(1'b1, IDX_RESET_CAUSE, 8'h03);
        bus(1'b1, IDX_INT_GLOBAL_CTRL, 8'h38);
        cfg <= 1'b0;
        pulse(14'h2000);
        rdc(IDX_RESET_CAUSE, 8'h03);
        cfg <= 1'b1;
        pulse(14'h2000);
        rdc(IDX_RESET_CAUSE, 8'h02);
        rdc(IDX_INT_GLOBAL_CTRL, 8'h00);
    endtask : t_brownout
    task automatic t_irq;
        bus(1'b1, IDX_EVT_STATUS, 8'h07);
        pulse(14'h0008);
        rdc(IDX_FLAGS_A, 8'h01);
        irqc(1'b0, 1'b0);
        bus(1'b1, IDX_EVT_MASK, 8'h02);
        irqc(1'b0, 1'b1);
        bus(1'b1, IDX_EVT_STATUS, 8'h02);
        irqc(1'b0, 1'b0);
        rdc(IDX_EVT_STATUS, 8'h00);
    endtask : t_irq
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_access();
        t_events();
        t_brownout();
        t_irq();
        complete_run();
    end
endmodule : test_periph_irq_and_reset_flags
